// *** design/evfu_consts.vh ***
/*
 holds the shared constants of the exception vector and frame unit.
 assumes inclusion by bare name from design files under design/.
*/
`ifndef EVFU_CONSTS_VH
`define EVFU_CONSTS_VH
// status word bit positions
`define EVFU_SUPER_BIT 13
`define EVFU_TRACE_BIT 15
// vector table geometry
`define EVFU_BASE_MSB 31
`define EVFU_BASE_LSB 20
`define EVFU_OFS_W 10
`define EVFU_VEC_W 8
`define EVFU_SYS_VEC_LAST 8'h3F
// frame layout
`define EVFU_FMT_BASE 2'h1
`define EVFU_FRAME_BYTES 32'h0000_0008
// fault status codes
`define EVFU_FS_NONE 4'h0
`define EVFU_FS_IFETCH 4'h4
`define EVFU_FS_OPWR 4'h8
`define EVFU_FS_WPROT 4'h9
`define EVFU_FS_OPRD 4'hC
// fault kind input codes
`define EVFU_FK_NONE 3'h0
`define EVFU_FK_IFETCH 3'h1
`define EVFU_FK_OPWR 3'h2
`define EVFU_FK_WPROT 3'h3
`define EVFU_FK_OPRD 3'h4
// interrupt event bits
`define EVFU_IRQ_W 2
`define EVFU_EV_ENTRY 0
`define EVFU_EV_DONE 1
// register indices
`define EVFU_REG_VBR 2'h0
`define EVFU_REG_STAT 2'h1
`define EVFU_REG_CLR 2'h2
`define EVFU_REG_EN 2'h3
`endif

// *** design/evfu_vec_decode.v ***
/*
 vector classifier: decides stacked pc kind and vector class.
 assumes a pure combinational context; no clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "evfu_consts.vh"
module evfu_vec_decode
(
   // vector in
   input wire [7:0] vec_in,
   // classification out
   output reg pc_next_out,
   output wire sys_vec_out,
   output reg valid_out
);
   assign sys_vec_out = (vec_in <= `EVFU_SYS_VEC_LAST);
   always @*
   begin
      pc_next_out = 1'b0;
      valid_out = 1'b1;
      // reserved and reset vectors still run, stacking the fault pc
      if (vec_in == 8'h09 || vec_in == 8'h0C || vec_in == 8'h0F)
         pc_next_out = 1'b1;
      else if (vec_in >= 8'h18 && vec_in <= 8'h2F)
         pc_next_out = 1'b1;
      else if (vec_in > `EVFU_SYS_VEC_LAST)
         pc_next_out = 1'b1;
      if (vec_in <= 8'h01 || vec_in == 8'h06 || vec_in == 8'h07 || vec_in == 8'h0D)
         valid_out = 1'b0;
      else if ((vec_in >= 8'h10 && vec_in <= 8'h17) || (vec_in >= 8'h30 && vec_in <= 8'h3C))
         valid_out = 1'b0;
      else if (vec_in == 8'h3E || vec_in == 8'h3F)
         valid_out = 1'b0;
   end
endmodule
`default_nettype wire

// *** design/evfu_frame_build.v ***
/*
 frame word builder: format/vector/status word and realigned stack pointer.
 assumes inputs stable during the entry cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "evfu_consts.vh"
module evfu_frame_build
(
   // context in
   input wire [31:0] sp_in,
   input wire [3:0] fs_in,
   input wire [7:0] vec_in,
   input wire [15:0] psw_in,
   // frame out
   output wire [31:0] word0_out,
   output wire [31:0] new_sp_out
);
   wire [3:0] fmt;
   wire [31:0] frame_top;
   assign fmt = {`EVFU_FMT_BASE, sp_in[1:0]};
   // fs sits split around the vector: fs[3:2] at 27:26, fs[1:0] at 17:16
   assign word0_out = {fmt, fs_in[3:2], vec_in, fs_in[1:0], psw_in};
   assign frame_top = {sp_in[31:2], 2'b00};
   assign new_sp_out = frame_top - `EVFU_FRAME_BYTES;
endmodule
`default_nettype wire

// *** design/evfu_top.v ***
/*
 exception vector and frame unit: entry sequencer, frame writes, vector fetch.
 assumes a pipeline that raises a one-cycle entry request and a memory bus
 with a ready handshake for each write or read.
*/
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "evfu_consts.vh"
// What this block does
// - copy status, set supervisor, clear trace first
// - one fixed frame length for all
// - table base register, 1-Mbyte aligned
// - table offset is four times vector
// - finish once handler opcode fetch starts
// - table is 1024 bytes long
// - 256 vectors, 64 system, 192 user
// - fault or next pc per vector
// - block interrupts during first handler instruction
// - two longwords: format/vector/status, then pc
// - format field 4..7 from stack misalignment
// - stack becomes aligned, minus 8 to 11
// - fault status field filled for errors
// - fault status encodings 0,4,8,9,C
// - 8-bit vector, internal or from peripheral
module evfu_top
(
   // clock and reset
   input wire clk_in,
   input wire rst_in,
   // pipeline entry request
   input wire exc_req_in,
   input wire exc_is_irq_in,
   input wire [7:0] exc_vec_in,
   input wire [7:0] irq_vec_in,
   input wire [2:0] fault_kind_in,
   input wire [31:0] fault_pc_in,
   input wire [31:0] next_pc_in,
   input wire [15:0] psw_in,
   input wire [31:0] sp_in,
   input wire first_insn_done_in,
   // pipeline results
   output reg busy_out,
   output reg [15:0] psw_new_out,
   output reg [31:0] sp_new_out,
   output reg [31:0] handler_pc_out,
   output reg handler_go_out,
   output wire irq_inhibit_out,
   output reg bad_vec_out,
   // memory bus
   output reg mem_req_out,
   output reg mem_we_out,
   output reg [31:0] mem_addr_out,
   output reg [31:0] mem_wdata_out,
   input wire mem_ready_in,
   input wire [31:0] mem_rdata_in,
   // register port
   input wire [1:0] reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [31:0] reg_rdata_out,
   // interrupt
   output wire irq_out
);
   localparam ST_IDLE = 3'd0;
   localparam ST_WR0 = 3'd1;
   localparam ST_WR1 = 3'd2;
   localparam ST_VEC = 3'd3;
   localparam ST_GO = 3'd4;
   // zero gap between the base field and the scaled vector offset
   localparam VEC_PAD_W = 32 - `EVFU_OFS_W - (`EVFU_BASE_MSB - `EVFU_BASE_LSB + 1);

   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [11:0] vector_table_base_reg_ff;
   reg [7:0] vec_ff;
   reg [31:0] pc_ff;
   reg [31:0] word0_ff;
   reg [31:0] sp_ff;
   reg inhibit_ff;
   reg [1:0] stat_ff;
   reg [1:0] en_ff;
   reg [7:0] last_vec_ff;
   reg [`EVFU_IRQ_W-1:0] stat_set;
   reg [31:0] nxt_rdata;

   wire [7:0] vec_sel;
   wire pc_next;
   wire sys_vec;
   wire vec_valid;
   wire [3:0] fault_status_field;
   wire [31:0] word0;
   wire [31:0] new_sp;
   wire [15:0] psw_entry;
   wire entry;
   wire done;
   wire [`EVFU_IRQ_W-1:0] stat_clr;
   wire [31:0] stacked_pc;
   wire [31:0] vec_addr;
   wire [31:0] frame_pc_addr;

   // one hot-free encoding keeps reserved kinds reading as no error
   function [3:0] evfu_fs_enc;
      input [2:0] kind;
      begin
         case (kind)
            `EVFU_FK_IFETCH: evfu_fs_enc = `EVFU_FS_IFETCH;
            `EVFU_FK_OPWR: evfu_fs_enc = `EVFU_FS_OPWR;
            `EVFU_FK_WPROT: evfu_fs_enc = `EVFU_FS_WPROT;
            `EVFU_FK_OPRD: evfu_fs_enc = `EVFU_FS_OPRD;
            default: evfu_fs_enc = `EVFU_FS_NONE;
         endcase
      end
   endfunction

   function [31:0] evfu_vec_addr;
      input [11:0] base;
      input [7:0] vec;
      begin
         evfu_vec_addr = {base, {VEC_PAD_W{1'b0}}, vec, 2'b00};
      end
   endfunction

   assign entry = exc_req_in && (state_ff == ST_IDLE);
   assign vec_sel = exc_is_irq_in ? irq_vec_in : exc_vec_in;
   assign fault_status_field = evfu_fs_enc(fault_kind_in);
   assign psw_entry = (psw_in | (16'h0001 << `EVFU_SUPER_BIT)) & ~(16'h0001 << `EVFU_TRACE_BIT);
   assign stacked_pc = pc_next ? next_pc_in : fault_pc_in;
   assign vec_addr = evfu_vec_addr(vector_table_base_reg_ff, vec_ff);
   assign frame_pc_addr = sp_ff + 32'h0000_0004;

   evfu_vec_decode u_dec
   (
      .vec_in(vec_sel),
      .pc_next_out(pc_next),
      .sys_vec_out(sys_vec),
      .valid_out(vec_valid)
   );

   evfu_frame_build u_frm
   (
      .sp_in(sp_in),
      .fs_in(fault_status_field),
      .vec_in(vec_sel),
      .psw_in(psw_in),
      .word0_out(word0),
      .new_sp_out(new_sp)
   );

   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
            if (exc_req_in)
               nxt_state = ST_WR0;
         ST_WR0:
            if (mem_ready_in)
               nxt_state = ST_WR1;
         ST_WR1:
            if (mem_ready_in)
               nxt_state = ST_VEC;
         ST_VEC:
            if (mem_ready_in)
               nxt_state = ST_GO;
         ST_GO:
            nxt_state = ST_IDLE;
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   assign done = (state_ff == ST_GO);

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_ff <= ST_IDLE;
         vec_ff <= 8'h00;
         pc_ff <= 32'h0000_0000;
         word0_ff <= 32'h0000_0000;
         sp_ff <= 32'h0000_0000;
         psw_new_out <= 16'h0000;
         sp_new_out <= 32'h0000_0000;
         handler_pc_out <= 32'h0000_0000;
         bad_vec_out <= 1'b0;
         last_vec_ff <= 8'h00;
      end
      else
      begin
         state_ff <= nxt_state;
         if (entry)
         begin
            vec_ff <= vec_sel;
            pc_ff <= stacked_pc;
            word0_ff <= word0;
            sp_ff <= new_sp;
            psw_new_out <= psw_entry;
            bad_vec_out <= ~vec_valid & sys_vec;
            last_vec_ff <= vec_sel;
         end
         if (state_ff == ST_VEC && mem_ready_in)
         begin
            handler_pc_out <= mem_rdata_in;
            sp_new_out <= sp_ff;
         end
      end
   end

   // memory bus drive: frame at sp, pc above it, then the table read
   always @*
   begin
      mem_req_out = 1'b0;
      mem_we_out = 1'b0;
      mem_addr_out = 32'h0000_0000;
      mem_wdata_out = 32'h0000_0000;
      busy_out = (state_ff != ST_IDLE);
      handler_go_out = done;
      case (state_ff)
         ST_WR0:
         begin
            mem_req_out = 1'b1;
            mem_we_out = 1'b1;
            mem_addr_out = sp_ff;
            mem_wdata_out = word0_ff;
         end
         ST_WR1:
         begin
            mem_req_out = 1'b1;
            mem_we_out = 1'b1;
            mem_addr_out = frame_pc_addr;
            mem_wdata_out = pc_ff;
         end
         ST_VEC:
         begin
            mem_req_out = 1'b1;
            mem_addr_out = vec_addr;
         end
         default:
         begin
            mem_req_out = 1'b0;
         end
      endcase
   end

   // inhibit from handler start until its first instruction retires
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         inhibit_ff <= 1'b0;
      else if (done)
         inhibit_ff <= 1'b1;
      else if (first_insn_done_in)
         inhibit_ff <= 1'b0;
   end
   assign irq_inhibit_out = inhibit_ff | busy_out;

   // registers: set wins over clear on status
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         vector_table_base_reg_ff <= 12'h000;
         stat_ff <= 2'b00;
         en_ff <= 2'b00;
         reg_rdata_out <= 32'h0000_0000;
      end
      else
      begin
         if (reg_wr_in && reg_addr_in == `EVFU_REG_VBR)
            vector_table_base_reg_ff <= reg_wdata_in[`EVFU_BASE_MSB:`EVFU_BASE_LSB];
         if (reg_wr_in && reg_addr_in == `EVFU_REG_EN)
            en_ff <= reg_wdata_in[`EVFU_IRQ_W-1:0];
         // an event in the clear cycle stays visible
         stat_ff <= (stat_ff & ~stat_clr) | stat_set;
         reg_rdata_out <= nxt_rdata;
      end
   end

   always @*
   begin
      stat_set = {`EVFU_IRQ_W{1'b0}};
      stat_set[`EVFU_EV_ENTRY] = entry;
      stat_set[`EVFU_EV_DONE] = done;
   end
   assign stat_clr = (reg_wr_in && reg_addr_in == `EVFU_REG_CLR) ? reg_wdata_in[`EVFU_IRQ_W-1:0] : {`EVFU_IRQ_W{1'b0}};

   // read data is zero outside the cycle after a read strobe
   always @*
   begin
      nxt_rdata = 32'h0000_0000;
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            `EVFU_REG_VBR: nxt_rdata = {vector_table_base_reg_ff, 20'h0_0000};
            `EVFU_REG_STAT: nxt_rdata = {16'h0000, last_vec_ff, 6'h00, stat_ff};
            `EVFU_REG_EN: nxt_rdata = {30'h0000_0000, en_ff};
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end
   assign irq_out = |(stat_ff & en_ff);
endmodule
`default_nettype wire

// *** tb/evfu_mem_model.sv ***
/*
 memory bus partner: answers each request after a set delay, logs the writes.
 assumes the requester holds every bus signal until ready is seen.
*/
`timescale 1ns/100ps
`default_nettype none
module evfu_mem_model
(
   // bus from the unit
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [3:0] dly_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [31:0] addr_in,
   input wire logic [31:0] wdata_in,
   // answer
   output logic ready_out,
   output logic [31:0] rdata_out
);
   logic [3:0] cnt_ff;
   logic wn_ff;
   logic [31:0] wa [0:1];
   logic [31:0] wd [0:1];
   always @(posedge clk_in or posedge rst_in)
      if (rst_in)
      begin
         ready_out <= 1'b0;
         rdata_out <= 32'h0000_0000;
         cnt_ff <= 4'h0;
         wn_ff <= 1'b0;
      end
      else
      begin
         ready_out <= 1'b0;
         // outside a read answer the data lines invert every cycle, so the last value returns every second cycle
         rdata_out <= ~rdata_out;
         if (req_in && !ready_out && cnt_ff == dly_in)
         begin
            ready_out <= 1'b1;
            cnt_ff <= 4'h0;
            if (we_in)
            begin
               wa[wn_ff] <= addr_in;
               wd[wn_ff] <= wdata_in;
               wn_ff <= !wn_ff;
            end
            else
               rdata_out <= addr_in ^ 32'h5A5A_0000;
         end
         else if (req_in && !ready_out)
            cnt_ff <= cnt_ff + 4'h1;
      end
endmodule
`default_nettype wire

// *** tb/evfu_chk_sva.sv ***
/*
 checker of the exception entry sequence at the unit's ports.
 assumes one clock and the asynchronous active high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module evfu_chk
(
   // watched ports
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic exc_req_in,
   input wire logic exc_is_irq_in,
   input wire logic [7:0] exc_vec_in,
   input wire logic [7:0] irq_vec_in,
   input wire logic [2:0] fault_kind_in,
   input wire logic [15:0] psw_in,
   input wire logic [31:0] sp_in,
   input wire logic busy_out,
   input wire logic [15:0] psw_new_out,
   input wire logic [31:0] sp_new_out,
   input wire logic [31:0] handler_pc_out,
   input wire logic handler_go_out,
   input wire logic irq_inhibit_out,
   input wire logic mem_req_out,
   input wire logic mem_we_out,
   input wire logic [31:0] mem_addr_out,
   input wire logic [31:0] mem_wdata_out,
   input wire logic mem_ready_in,
   input wire logic [31:0] mem_rdata_in
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic take;
   logic [1:0] wcnt_ff;
   logic [7:0] vec_seen_ff;
   assign take = exc_req_in && !busy_out;
   function automatic [3:0] fs_of(input [2:0] k);
      fs_of = k == 3'h1 ? 4'h4 : k == 3'h2 ? 4'h8 : k == 3'h3 ? 4'h9 : k == 3'h4 ? 4'hC : 4'h0;
   endfunction
   always_ff @(posedge clk_in or posedge rst_in)
      if (rst_in)
         wcnt_ff <= 2'h0;
      else if (take)
         wcnt_ff <= 2'h0;
      else if (mem_req_out && mem_we_out && mem_ready_in)
         wcnt_ff <= wcnt_ff + 2'h1;
   always_ff @(posedge clk_in or posedge rst_in)
      if (rst_in)
         vec_seen_ff <= 8'h00;
      else if (take)
         vec_seen_ff <= exc_is_irq_in ? irq_vec_in : exc_vec_in;
   sequence s_wr_done; mem_req_out && mem_we_out && mem_ready_in; endsequence
   sequence s_rd_done; mem_req_out && !mem_we_out && mem_ready_in; endsequence
   property p_psw; take |=> psw_new_out == (($past(psw_in) | 16'h2000) & 16'h7FFF); endproperty
   a_psw: assert property (p_psw) else $error("status copy wrong");
   property p_word0; take |=> mem_req_out && mem_we_out && mem_wdata_out[15:0] == $past(psw_in)
      && mem_addr_out == (($past(sp_in) & 32'hFFFF_FFFC) - 32'h0000_0008)
      && mem_wdata_out[31:28] == {2'b01, $past(sp_in[1:0])}; endproperty
   a_word0: assert property (p_word0) else $error("first frame word wrong");
   property p_fs; take |=> {mem_wdata_out[27:26], mem_wdata_out[17:16]} == fs_of($past(fault_kind_in))
      && mem_wdata_out[25:18] == ($past(exc_is_irq_in) ? $past(irq_vec_in) : $past(exc_vec_in)); endproperty
   a_fs: assert property (p_fs) else $error("fault status or vector wrong");
   property p_hold; mem_req_out && !mem_ready_in |=> mem_req_out && $stable(mem_addr_out)
      && $stable(mem_wdata_out) && $stable(mem_we_out); endproperty
   a_hold: assert property (p_hold) else $error("bus request dropped early");
   property p_word1; s_wr_done ##0 wcnt_ff == 2'h0 |=> mem_req_out && mem_we_out
      && mem_addr_out == $past(mem_addr_out) + 32'h0000_0004; endproperty
   a_word1: assert property (p_word1) else $error("second frame word misplaced");
   property p_len; s_rd_done |-> wcnt_ff == 2'h2; endproperty
   a_len: assert property (p_len) else $error("frame length wrong");
   property p_vec; mem_req_out && !mem_we_out |-> mem_addr_out[19:10] == 10'h000
      && mem_addr_out[9:2] == vec_seen_ff && mem_addr_out[1:0] == 2'h0; endproperty
   a_vec: assert property (p_vec) else $error("vector address wrong");
   property p_go; s_rd_done |=> handler_go_out ##1 !handler_go_out && irq_inhibit_out; endproperty
   a_go: assert property (p_go) else $error("handler start wrong");
   property p_load; s_rd_done |=> handler_pc_out == $past(mem_rdata_in) && sp_new_out[1:0] == 2'h0; endproperty
   a_load: assert property (p_load) else $error("handler or stack load wrong");
   property p_inh; busy_out |-> irq_inhibit_out; endproperty
   a_inh: assert property (p_inh) else $error("interrupts not held off");
endmodule
bind evfu_top evfu_chk u_chk (.clk_in, .rst_in, .exc_req_in, .exc_is_irq_in, .exc_vec_in, .irq_vec_in,
   .fault_kind_in, .psw_in, .sp_in, .busy_out, .psw_new_out, .sp_new_out, .handler_pc_out, .handler_go_out,
   .irq_inhibit_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_ready_in, .mem_rdata_in);
`default_nettype wire

// *** tb/testbench.sv ***
/*
 self-checking bench: register access, exception entries, interrupt events.
 assumes the unit and the memory partner model share one 200 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk_in, rst_in, exc_req_in, exc_is_irq_in, first_insn_done_in, reg_wr_in, reg_rd_in;
   logic busy_out, handler_go_out, irq_inhibit_out, bad_vec_out, mem_req_out, mem_we_out, mem_ready_in, irq_out;
   logic [7:0] exc_vec_in, irq_vec_in;
   logic [2:0] fault_kind_in;
   logic [31:0] fault_pc_in, next_pc_in, sp_in, sp_new_out, handler_pc_out, mem_addr_out, mem_wdata_out;
   logic [31:0] mem_rdata_in, reg_wdata_in, reg_rdata_out;
   logic [15:0] psw_in, psw_new_out;
   logic [1:0] reg_addr_in;
   logic [3:0] dly;
   integer n_mismatch = 0, n_tests = 0, k;
   evfu_top DUT (.clk_in, .rst_in, .exc_req_in, .exc_is_irq_in, .exc_vec_in, .irq_vec_in, .fault_kind_in,
      .fault_pc_in, .next_pc_in, .psw_in, .sp_in, .first_insn_done_in, .busy_out, .psw_new_out, .sp_new_out,
      .handler_pc_out, .handler_go_out, .irq_inhibit_out, .bad_vec_out, .mem_req_out, .mem_we_out, .mem_addr_out,
      .mem_wdata_out, .mem_ready_in, .mem_rdata_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out, .irq_out);
   evfu_mem_model mem (.clk_in, .rst_in, .dly_in(dly), .req_in(mem_req_out), .we_in(mem_we_out),
      .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .ready_out(mem_ready_in), .rdata_out(mem_rdata_in));
   initial
   begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [1:0] a, input logic [31:0] exp, input string nm);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 chk(nm, reg_rdata_out, exp);
   endtask
   task automatic entry(input logic [7:0] v, input logic irq, input logic [2:0] fk, input logic [3:0] efs,
      input logic [31:0] sp);
      logic [31:0] ens, pc;
      logic bad;
      ens = (sp & 32'hFFFF_FFFC) - 32'h0000_0008;
      // reserved vectors are still taken and stack the faulting pc
      pc = (v inside {9, 12, 15, [24:47], [64:255]}) ? next_pc_in : fault_pc_in;
      bad = v inside {[0:1], 6, 7, 13, [16:23], [48:60], 62, 63};
      @(posedge clk_in);
      exc_is_irq_in <= irq;
      exc_vec_in <= irq ? 8'h05 : v;
      irq_vec_in <= v;
      fault_kind_in <= fk;
      sp_in <= sp;
      exc_req_in <= 1'b1;
      // the second request cycle lands while busy and must be ignored
      @(posedge clk_in);
      @(posedge clk_in);
      exc_req_in <= 1'b0;
      for (k = 0; k < 40 && handler_go_out !== 1'b1; k++)
         @(posedge clk_in) #1;
      if (k == 40)
      begin
         chk("handler start", handler_go_out, 32'h0000_0001);
         tally_and_finish;
      end
      else
      begin
         chk("status copy", psw_new_out, 32'h0000_2013);
         chk("word0 addr", mem.wa[0], ens);
         chk("word0", mem.wd[0], {2'b01, sp[1:0], efs[3:2], v, efs[1:0], psw_in});
         chk("word1 addr", mem.wa[1], ens + 32'h0000_0004);
         chk("stacked pc", mem.wd[1], pc);
         chk("new sp", sp_new_out, ens);
         chk("bad vector", bad_vec_out, bad);
         chk("handler", handler_pc_out, {12'hABC, 10'h000, v, 2'b00} ^ 32'h5A5A_0000);
         @(posedge clk_in);
         first_insn_done_in <= 1'b1;
         #1 chk("inhibit", irq_inhibit_out, 32'h0000_0001);
         chk("busy", busy_out, 32'h0000_0000);
         @(posedge clk_in);
         first_insn_done_in <= 1'b0;
         #1 chk("inhibit end", irq_inhibit_out, 32'h0000_0000);
      end
   endtask
   initial
   begin
      rst_in = 1'b1;
      {exc_req_in, exc_is_irq_in, first_insn_done_in, reg_wr_in, reg_rd_in} = 5'h00;
      {exc_vec_in, irq_vec_in, fault_kind_in, reg_addr_in, reg_wdata_in, sp_in} = 0;
      fault_pc_in = 32'h0000_1000;
      next_pc_in = 32'h0000_1004;
      psw_in = 16'h8013;
      dly = 4'h0;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(2'h0, 32'h0000_0000, "base reset");
      rd(2'h1, 32'h0000_0000, "status reset");
      wr(2'h0, 32'hABCD_1234);
      rd(2'h0, 32'hABC0_0000, "base");
      wr(2'h3, 32'h0000_0003);
      rd(2'h3, 32'h0000_0003, "enable");
      $display("register test done");
      entry(8'h02, 1'b0, 3'h1, 4'h4, 32'h0000_8000);
      dly <= 4'h3;
      entry(8'h09, 1'b0, 3'h2, 4'h8, 32'h0000_8001);
      entry(8'h3D, 1'b0, 3'h3, 4'h9, 32'h0000_8002);
      dly <= 4'h0;
      entry(8'h40, 1'b1, 3'h4, 4'hC, 32'h0000_8003);
      entry(8'h06, 1'b0, 3'h5, 4'h0, 32'h0000_8000);
      entry(8'hFF, 1'b0, 3'h0, 4'h0, 32'h0000_8007);
      $display("entry test done");
      rd(2'h1, 32'h0000_FF03, "status");
      chk("irq set", irq_out, 32'h0000_0001);
      wr(2'h3, 32'h0000_0000);
      chk("irq masked", irq_out, 32'h0000_0000);
      wr(2'h3, 32'h0000_0003);
      wr(2'h2, 32'h0000_0003);
      chk("irq cleared", irq_out, 32'h0000_0000);
      $display("interrupt test done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
